// *** verilog/rlps_regs.sv ***
// top of the rate lock and power save register group
// assumes a byte-wide register port, one access per cycle, synchronous inputs
`timescale 1ns/1ps
module rlps_regs (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // register port
  input  wire rlps_pkg::rlps_req_t       req,
  output logic [7:0]                     rdata,
  output logic                           rvalid,
  // equalizer side
  input  wire logic                      coarse_adapt_done,
  input  wire logic                      carrier_present_indication,
  input  wire logic                      cable_input_selected,
  output logic                           lock_status,
  output logic                           power_save,
  // recovery loop
  output rlps_pkg::rlps_rate_en_t        rate_lock_allow
);
  typedef struct packed {
    logic [7:0] eq_ctrl;
    logic [7:0] rate_lock;
    logic [7:0] rdata_p;
    logic       rd_p;
    logic       sel_rsvd;
    logic [7:0] rdata;
    logic       rvalid;
    logic       lock_status;
    logic [4:0] rate_allow;
  } rlps_st_t;
  rlps_st_t st;
  rlps_st_t next_st;

  function automatic logic [4:0] rsvd_index(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h1F;
    for (int i = 0; i < rlps_pkg::RLPS_RSVD_COUNT; i++) begin
      if (a == rlps_pkg::RLPS_RSVD_OFS[i]) r = 5'(i);
    end
    return r;
  endfunction

  logic [4:0] ridx;
  logic       rsvd_hit;
  logic [7:0] rsvd_rdata;
  logic       ps_now;
  logic [7:0] eq_stat;
  logic [7:0] drv_stat;
  logic       wr_eq;
  logic       wr_rate;
  logic       rd_eq;
  logic       rd_rate;
  logic       rd_eq_stat;
  logic       rd_drv_stat;

  assign ridx     = rsvd_index(req.addr);
  assign rsvd_hit = (ridx != 5'h1F);

  // address decodes used by the checks below
  assign wr_eq       = req.wr && (req.addr == rlps_pkg::RLPS_OFS_EQ_CTRL);
  assign wr_rate     = req.wr && (req.addr == rlps_pkg::RLPS_OFS_RATE_LOCK);
  assign rd_eq       = req.rd && (req.addr == rlps_pkg::RLPS_OFS_EQ_CTRL);
  assign rd_rate     = req.rd && (req.addr == rlps_pkg::RLPS_OFS_RATE_LOCK);
  assign rd_eq_stat  = req.rd && (req.addr == rlps_pkg::RLPS_OFS_EQ_STAT);
  assign rd_drv_stat = req.rd && (req.addr == rlps_pkg::RLPS_OFS_DRV_STAT);

  rlps_rsvd_mem u_rsvd (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (req.wr && rsvd_hit),
    .idx      (ridx[3:0]),
    .wdata    (req.wdata),
    .rdata    (rsvd_rdata)
  );

  rlps_ps_ctrl u_ps (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .power_save_override  (st.eq_ctrl[rlps_pkg::RLPS_BIT_PS_OV]),
    .power_save_setting   (st.eq_ctrl[rlps_pkg::RLPS_BIT_PS_HI:rlps_pkg::RLPS_BIT_PS_LO]),
    .carrier_present      (carrier_present_indication),
    .cable_input_selected (cable_input_selected),
    .power_save           (ps_now)
  );

  always_comb begin
    eq_stat = 8'h00;
    eq_stat[rlps_pkg::RLPS_BIT_CD_STAT] = carrier_present_indication; // RL15
    eq_stat[0] = coarse_adapt_done;
    drv_stat = 8'h00;
    drv_stat[rlps_pkg::RLPS_BIT_PS_STAT] = ps_now; // RL14
  end

  always_comb begin
    next_st = st;
    next_st.rd_p = req.rd;
    next_st.sel_rsvd = req.rd && rsvd_hit;
    // soft reset pulse lasts one cycle and never reads back as one
    if (st.eq_ctrl[rlps_pkg::RLPS_BIT_SOFT]) begin
      next_st.eq_ctrl = rlps_pkg::RLPS_RST_EQ_CTRL; // RL12
    end
    if (req.wr) begin
      case (req.addr)
        rlps_pkg::RLPS_OFS_EQ_CTRL:   next_st.eq_ctrl = req.wdata; // RL16
        rlps_pkg::RLPS_OFS_RATE_LOCK: next_st.rate_lock = req.wdata; // RL16
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        rlps_pkg::RLPS_OFS_EQ_CTRL: begin
          next_st.rdata_p = st.eq_ctrl & ~(8'h01 << rlps_pkg::RLPS_BIT_SOFT); // RL12
        end
        rlps_pkg::RLPS_OFS_EQ_STAT:   next_st.rdata_p = eq_stat;
        rlps_pkg::RLPS_OFS_DRV_STAT:  next_st.rdata_p = drv_stat;
        rlps_pkg::RLPS_OFS_RATE_LOCK: next_st.rdata_p = st.rate_lock;
        default:                      next_st.rdata_p = 8'h00;
      endcase
    end
    // second read stage keeps every output a plain flop, at one more cycle of latency
    next_st.rvalid = st.rd_p;
    if (st.rd_p) begin
      next_st.rdata = st.sel_rsvd ? rsvd_rdata : st.rdata_p;
    end
    if (st.eq_ctrl[rlps_pkg::RLPS_BIT_SRC_SEL]) begin
      next_st.lock_status = carrier_present_indication; // RL7
    end else begin
      next_st.lock_status = coarse_adapt_done; // RL6
    end
    next_st.rate_allow = st.rate_lock[4:0]; // RL1 RL2 RL3 RL4 RL5
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.eq_ctrl     <= rlps_pkg::RLPS_RST_EQ_CTRL;
      st.rate_lock   <= rlps_pkg::RLPS_RST_RATE_LOCK; // RL17
      st.rdata_p     <= 8'h00;
      st.rd_p        <= 1'b0;
      st.sel_rsvd    <= 1'b0;
      st.rdata       <= 8'h00;
      st.rvalid      <= 1'b0;
      st.lock_status <= 1'b0;
      st.rate_allow  <= 5'h1F;
    end else begin
      st <= next_st;
    end
  end

  assign rdata            = st.rdata;
  assign rvalid           = st.rvalid;
  assign lock_status      = st.lock_status;
  assign power_save       = ps_now;
  assign rate_lock_allow  = st.rate_allow;

  // rate enables: a write lands in the register, then in the loop enables one cycle later
  AST_RATE_FOLLOW: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
    wr_rate |-> ##2 rate_lock_allow == $past(req.wdata[4:0], 2))
    else $error("rate enables did not follow write");
  AST_SD_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
    wr_rate && !req.wdata[4] |-> ##2 !rate_lock_allow.sd)
    else $error("270M lock still allowed");
  AST_SD_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
    wr_rate && req.wdata[4] |-> ##2 rate_lock_allow.sd)
    else $error("270M lock not allowed");
  AST_HD_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
    wr_rate && !req.wdata[3] |-> ##2 !rate_lock_allow.hd)
    else $error("1.5G lock still allowed");
  AST_HD_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
    wr_rate && req.wdata[3] |-> ##2 rate_lock_allow.hd)
    else $error("1.5G lock not allowed");
  AST_G3_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
    wr_rate && !req.wdata[2] |-> ##2 !rate_lock_allow.g3)
    else $error("3G lock still allowed");
  AST_G3_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
    wr_rate && req.wdata[2] |-> ##2 rate_lock_allow.g3)
    else $error("3G lock not allowed");
  AST_G6_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
    wr_rate && !req.wdata[1] |-> ##2 !rate_lock_allow.g6)
    else $error("6G lock still allowed");
  AST_G6_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
    wr_rate && req.wdata[1] |-> ##2 rate_lock_allow.g6)
    else $error("6G lock not allowed");
  AST_G12_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
    wr_rate && !req.wdata[0] |-> ##2 !rate_lock_allow.g12)
    else $error("12G lock still allowed");
  AST_G12_ON: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
    wr_rate && req.wdata[0] |-> ##2 rate_lock_allow.g12)
    else $error("12G lock not allowed");
  AST_RATE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
    !wr_rate |=> $stable(st.rate_lock))
    else $error("rate enables changed without a write");
  AST_RATE_RESET: assert property (@(posedge core_clk) disable iff (!rst_n) // RL17
    $rose(rst_n) |-> rate_lock_allow == 5'h1F
    && st.rate_lock == rlps_pkg::RLPS_RST_RATE_LOCK)
    else $error("rate enables not all set after reset");

  // lock pin source
  AST_LOCK_CD: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
    st.eq_ctrl[rlps_pkg::RLPS_BIT_SRC_SEL] |=> lock_status == $past(carrier_present_indication))
    else $error("lock pin not carrier");
  AST_LOCK_ADAPT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
    !st.eq_ctrl[rlps_pkg::RLPS_BIT_SRC_SEL] |=> lock_status == $past(coarse_adapt_done))
    else $error("lock pin not adaptation");

  // soft reset: restores the page one cycle after the write and never reads back as one
  AST_SOFT_CLR: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
    wr_eq && req.wdata[rlps_pkg::RLPS_BIT_SOFT] ##1 !wr_eq
    |=> st.eq_ctrl == rlps_pkg::RLPS_RST_EQ_CTRL) else $error("soft reset failed");
  AST_SOFT_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
    st.eq_ctrl[rlps_pkg::RLPS_BIT_SOFT] && !wr_eq
    |=> st.eq_ctrl == rlps_pkg::RLPS_RST_EQ_CTRL) else $error("soft reset bit stuck");
  AST_SOFT_RD: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
    rd_eq |=> ##1 rvalid
    && rdata == ($past(st.eq_ctrl, 2) & ~(8'h01 << rlps_pkg::RLPS_BIT_SOFT)))
    else $error("control byte read back wrong");

  // written bytes read back unchanged, reserved bits included, except a control byte written with the soft reset bit set
  AST_EQ_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
    wr_eq && !req.wdata[rlps_pkg::RLPS_BIT_SOFT] ##1 !req.wr ##1 rd_eq
    |=> ##1 rdata == $past(req.wdata, 4)) else $error("control byte not kept");
  AST_RATE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
    wr_rate ##1 !req.wr ##1 rd_rate
    |=> ##1 rdata == $past(req.wdata, 4)) else $error("rate byte not kept");
  AST_RSVD_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
    req.wr && rsvd_hit ##1 !req.wr ##1 req.rd && req.addr == $past(req.addr, 2)
    |=> ##1 rdata == $past(req.wdata, 4)) else $error("reserved byte not kept");

  // status reads
  AST_PS_STAT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14
    rd_drv_stat |=> ##1 rvalid && rdata[2] == $past(power_save, 2))
    else $error("power save status wrong");
  AST_CD_STAT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL15
    rd_eq_stat |=> ##1 rvalid && rdata[6] == $past(carrier_present_indication, 2))
    else $error("carrier status wrong");
endmodule

// *** verilog/rlps_pkg.sv ***
// package for the rate lock and power save register group
// assumes one byte-wide register port; offsets are byte addresses on each page
// How it works
// RL1: bit 4 of rate lock enables lets the loop lock to 270 Mbps
// RL2: bit 3 lets the loop lock to the 1.485 and 1.4835 Gbps rates
// RL3: bit 2 lets the loop lock to the 2.97 and 2.967 Gbps rates
// RL4: bit 1 lets the loop lock to the 5.94 and 5.934 Gbps rates
// RL5: bit 0 lets the loop lock to the 11.88 and 11.868 Gbps rates
// RL6: source select zero: lock pin shows coarse adaptation done on cable input
// RL7: source select one: lock pin shows carrier detect of cable input
// RL8: override clear: equalizer saves power whenever no input signal is seen
// RL9: override set: power saving follows the two-bit setting field instead
// RL10: setting 00 saves on no signal, 01 never, 11 forces; 10 reserved
// RL11: the input not selected for use is always powered down
// RL12: soft reset bit restores the equalizer page defaults and clears itself
// RL13: host must reinitialise the registers after a soft reset
// RL14: status bit 2 reads one while power saving is active
// RL15: status bit 6 reads one while a carrier is present on cable input
// RL16: reserved bits keep and read back what was written
// RL17: after reset all five rate enables read as one
package rlps_pkg;
  localparam logic [7:0] RLPS_OFS_EQ_CTRL    = 8'h00;
  localparam logic [7:0] RLPS_OFS_EQ_STAT    = 8'h01;
  localparam logic [7:0] RLPS_OFS_DRV_STAT   = 8'h02;
  localparam logic [7:0] RLPS_OFS_RSVD_FIRST = 8'h92;
  localparam logic [7:0] RLPS_OFS_RATE_LOCK  = 8'hA0;
  localparam logic [7:0] RLPS_RST_EQ_CTRL    = 8'h08;
  localparam logic [7:0] RLPS_RST_RATE_LOCK  = 8'h1F;
  localparam int         RLPS_RSVD_COUNT     = 11;
  // reserved defaults, index 0 at the lowest offset
  localparam logic [7:0] RLPS_RSVD_RESET [RLPS_RSVD_COUNT] = '{
    8'h2C, 8'h32, 8'h37, 8'h3E, 8'h3F, 8'h04, 8'h04, 8'h04, 8'h06, 8'h04, 8'h04};
  localparam logic [7:0] RLPS_RSVD_OFS [RLPS_RSVD_COUNT] = '{
    8'h92, 8'h93, 8'h94, 8'h95, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E};
  localparam int RLPS_BIT_SRC_SEL = 7;
  localparam int RLPS_BIT_PS_OV   = 5;
  localparam int RLPS_BIT_PS_HI   = 4;
  localparam int RLPS_BIT_PS_LO   = 3;
  localparam int RLPS_BIT_SOFT    = 2;
  localparam int RLPS_BIT_CD_STAT = 6;
  localparam int RLPS_BIT_PS_STAT = 2;
  localparam logic [1:0] RLPS_PS_NO_SIGNAL = 2'h0;
  localparam logic [1:0] RLPS_PS_NEVER     = 2'h1;
  localparam logic [1:0] RLPS_PS_FORCE     = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rlps_req_t;

  typedef struct packed {
    logic       sd;
    logic       hd;
    logic       g3;
    logic       g6;
    logic       g12;
  } rlps_rate_en_t;
endpackage

// *** verilog/rlps_rsvd_mem.sv ***
// reserved byte store: eleven read/write bytes with registered read data
// assumes index already decoded by the caller
`timescale 1ns/1ps
module rlps_rsvd_mem #(
  parameter int DEPTH = rlps_pkg::RLPS_RSVD_COUNT
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // access
  input  wire logic             wr_en,
  input  wire logic [3:0]       idx,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rdata;
  } rlps_mem_st_t;
  rlps_mem_st_t st;
  rlps_mem_st_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en && (32'(idx) < DEPTH)) begin
      next_st.mem[idx] = wdata; // RL16
    end
    next_st.rdata = (32'(idx) < DEPTH) ? st.mem[idx] : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        st.mem[i] <= rlps_pkg::RLPS_RSVD_RESET[i];
      end
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end
  assign rdata = st.rdata;
endmodule

// *** verilog/rlps_ps_ctrl.sv ***
// power save decision for the cable equalizer input
// assumes carrier and input selection are synchronous levels
`timescale 1ns/1ps
module rlps_ps_ctrl (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // controls
  input  wire logic       power_save_override,
  input  wire logic [1:0] power_save_setting,
  input  wire logic       carrier_present,
  input  wire logic       cable_input_selected,
  // result
  output logic            power_save
);
  typedef struct packed {
    logic ps;
  } rlps_ps_st_t;
  rlps_ps_st_t st;
  rlps_ps_st_t next_st;

  always_comb begin
    next_st = st;
    if (!cable_input_selected) begin
      next_st.ps = 1'b1; // RL11
    end else if (!power_save_override) begin
      next_st.ps = !carrier_present; // RL8
    end else begin
      case (power_save_setting) // RL9
        rlps_pkg::RLPS_PS_NO_SIGNAL: next_st.ps = !carrier_present; // RL10
        rlps_pkg::RLPS_PS_NEVER:     next_st.ps = 1'b0; // RL10
        rlps_pkg::RLPS_PS_FORCE:     next_st.ps = 1'b1; // RL10
        // reserved code treated as automatic; safer than powering down blindly
        default:                     next_st.ps = !carrier_present;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.ps <= 1'b0;
    end else begin
      st <= next_st;
    end
  end
  assign power_save = st.ps;

  AST_PS_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
    !cable_input_selected |=> power_save) else $error("unused input not powered down");
  AST_PS_AUTO: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
    cable_input_selected && !power_save_override |=> power_save == !$past(carrier_present))
    else $error("auto power save wrong");
  AST_PS_FORCE: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
    cable_input_selected && power_save_override
    && power_save_setting == rlps_pkg::RLPS_PS_FORCE |=> power_save)
    else $error("forced power save missing");
  AST_PS_NEVER: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
    cable_input_selected && power_save_override
    && power_save_setting == rlps_pkg::RLPS_PS_NEVER |=> !power_save)
    else $error("power save while disabled");
  AST_PS_NO_SIG: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
    cable_input_selected && power_save_override
    && power_save_setting == rlps_pkg::RLPS_PS_NO_SIGNAL
    |=> power_save == !$past(carrier_present))
    else $error("no-signal power save wrong");
endmodule

// *** dv/rlps_host.sv ***
// host model: issues byte reads and writes on the register port
// assumes the bench supplies the clock and releases reset first
`timescale 1ns/1ps
module rlps_host (
  // clock
  input  wire logic          core_clk,
  // register port
  output rlps_pkg::rlps_req_t req,
  input  wire logic [7:0]    rdata,
  input  wire logic          rvalid
);
  initial req = '0;

  // strobes drop after one taken edge, so back-to-back calls never overlap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1 req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 'x;
    @(posedge core_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk);
      #1 req = '0;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d  = rdata;
      end
    end
  endtask

  // page contents are lost on soft reset, so the host writes them again
  task automatic reinit(input logic [7:0] v);
    wr(8'h00, v);
  endtask
endmodule

// *** dv/rlps_regs_test.sv ***
// self-checking bench for the rate lock and power save register group
// assumes the host model in rlps_host and a 125 MHz core clock
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t got %h exp %h", $time, (g), (e)); end end
module rlps_regs_test;
  logic                    core_clk;
  logic                    rst_n;
  rlps_pkg::rlps_req_t     req;
  logic [7:0]              rdata;
  logic                    rvalid;
  logic                    adapt;
  logic                    carrier;
  logic                    sel;
  logic                    lock_status;
  logic                    power_save;
  rlps_pkg::rlps_rate_en_t rate_lock_allow;
  int                      error_cnt;
  int                      n_compared;

  rlps_regs rlps_regs_i (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid),
    .coarse_adapt_done(adapt), .carrier_present_indication(carrier),
    .cable_input_selected(sel), .lock_status(lock_status),
    .power_save(power_save), .rate_lock_allow(rate_lock_allow));
  rlps_host rlps_host_i (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    rlps_host_i.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      finish_test();
    end else begin
      `CHK(d & m, e)
    end
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    `CHK(rate_lock_allow, 5'h1F)
    rd_chk(8'hA0, 8'hFF, 8'h1F);
    rd_chk(8'h00, 8'hFF, 8'h08);
    rd_chk(rlps_pkg::RLPS_RSVD_OFS[0], 8'hFF, rlps_pkg::RLPS_RSVD_RESET[0]);
  endtask

  task automatic t_rates();
    for (int i = 0; i < 5; i++) begin
      rlps_host_i.wr(8'hA0, 8'hE0 | (8'h01 << i));
      rd_chk(8'hA0, 8'hFF, 8'hE0 | (8'h01 << i));
      `CHK(rate_lock_allow, 5'h01 << i)
    end
  endtask

  task automatic t_rsvd();
    logic [7:0] a;
    logic [7:0] v;
    for (int i = 0; i < rlps_pkg::RLPS_RSVD_COUNT; i++) begin
      a = rlps_pkg::RLPS_RSVD_OFS[i];
      v = rlps_pkg::RLPS_RSVD_RESET[i];
      rd_chk(a, 8'hFF, v);
      rlps_host_i.wr(a, ~v);
      rd_chk(a, 8'hFF, ~v);
    end
    rlps_host_i.wr(8'h50, 8'hAA);
    rd_chk(8'h50, 8'hFF, 8'h00);
  endtask

  task automatic t_lock();
    for (int k = 0; k < 8; k++) begin
      rlps_host_i.wr(8'h00, {k[2], 7'h08});
      adapt   = k[1];
      carrier = k[0];
      repeat (2) @(posedge core_clk);
      #1 `CHK(lock_status, k[2] ? k[0] : k[1])
      rd_chk(8'h01, 8'h41, {1'b0, k[0], 5'h00, k[1]});
    end
  endtask

  // setting 10 is reserved and is expected to behave as automatic
  task automatic t_power();
    logic e;
    for (int k = 0; k < 32; k++) begin
      rlps_host_i.wr(8'h00, {2'b00, k[4], k[3:2], 3'b000});
      carrier = k[1];
      sel     = k[0];
      e = !k[0] ? 1'b1 : (k[4] && k[3:2] == 2'b11) ? 1'b1 :
          (k[4] && k[3:2] == 2'b01) ? 1'b0 : !k[1];
      repeat (2) @(posedge core_clk);
      #1 `CHK(power_save, e)
      rd_chk(8'h02, 8'h04, {5'h00, e, 2'b00});
    end
  endtask

  task automatic t_soft();
    rlps_host_i.wr(8'h00, 8'hFB);
    rd_chk(8'h00, 8'hFF, 8'hFB);
    rlps_host_i.wr(8'h00, 8'hE4);
    rd_chk(8'h00, 8'hFF, 8'h08);
    rlps_host_i.reinit(8'hA3);
    rd_chk(8'h00, 8'hFF, 8'hA3);
  endtask

  initial begin
    rst_n      = 1'b0;
    adapt      = 1'b0;
    carrier    = 1'b0;
    sel        = 1'b1;
    error_cnt  = 0;
    n_compared = 0;
    t_reset();
    t_rates();
    t_rsvd();
    t_lock();
    t_power();
    t_soft();
    t_reset();
    finish_test();
  end
endmodule
